// ### move_instruction_executor.v
// word move instruction executor with ahb-lite register access
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`include "mov_exec_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - next option pre-steps selected accumulator pointer
// - accumulator to shift amount keeps 4 bits
// - memory to shift amount keeps 4 bits
// - shift amount stored as zero-extended word
// - immediate constant loads shift amount
// - pointer load from memory keeps 6 bits
// - immediate 5-bit constant loads pointer
// - multiplier operand loads from accumulator or memory clear unsigned flag
// - accumulator loads other than the copy between accumulator banks update condition flags
// - test condition writes chosen test flag
// - table lookup reads program word to accumulator
// - program word at accumulator stored to memory
// - repeat length stored as byte
// - repeat length loads one byte
// - immediate byte loads repeat length
// - memory word overwrites whole flags word
// - stack top loads from and stores to memory
// - data page pointer stored to memory
// - memory loads product high directly
module move_instruction_executor
(
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP
);
////////////////////////////////////////////////////////////////////////////////
// reset release
reg rst_a_q;
reg rst_b_q;
always @(posedge REF_CLK or negedge RST_N)
begin
  if (!RST_N)
  begin
    rst_a_q <= 1'b0;
    rst_b_q <= 1'b0;
  end
  else
  begin
    rst_a_q <= 1'b1;
    rst_b_q <= rst_a_q;
  end
end
wire rst_n = rst_b_q;
////////////////////////////////////////////////////////////////////////////////
// state
reg  [31:0] ctrl_q;
reg  [15:0] operand_q;
reg  [15:0] memdata_q;
reg  [15:0] romdata_q;
reg  [15:0] result_q;
reg         result_wr_q;
reg  [15:0] accum_reg     [0:3];
reg  [15:0] accum_offset_reg [0:3];
reg  [5:0]  accum_pointer_reg [0:3];
reg  [3:0]  shift_amount_reg;
reg  [15:0] multiplier_operand_reg;
reg  [15:0] product_high_reg;
reg  [7:0]  repeat_length_reg;
reg  [15:0] flags_q;
reg  [15:0] stack_top_reg;
reg  [15:0] data_page_pointer;
reg         ph_q;
reg  [7:0]  ph_addr_q;
reg         ph_wr_q;
integer     i;
wire [4:0]  form   = ctrl_q[`CTRL_FORM_LSB+4:`CTRL_FORM_LSB];
wire [1:0]  sel    = ctrl_q[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB];
wire        alt    = ctrl_q[`CTRL_ALT_BIT];
wire [1:0]  nxt    = ctrl_q[`CTRL_NEXT_LSB+1:`CTRL_NEXT_LSB];
wire        tf_sel = ctrl_q[`CTRL_TF_BIT];
wire [3:0]  cc     = ctrl_q[`CTRL_CC_LSB+3:`CTRL_CC_LSB];
wire        go     = ctrl_q[`CTRL_GO_BIT];
////////////////////////////////////////////////////////////////////////////////
// helpers
function [15:0] set_cond;
  input [15:0] f;
  input [15:0] v;
  begin
    set_cond = f;
    set_cond[`FLAG_ZF_BIT] = (v == 16'h0000);
    set_cond[`FLAG_SF_BIT] = v[15];
  end
endfunction
function test_condition;
  input [3:0]  c;
  input [15:0] f;
  begin
    case (c)
      4'h0: test_condition = 1'b1;
      4'h1: test_condition = f[`FLAG_ZF_BIT];
      4'h2: test_condition = ~f[`FLAG_ZF_BIT];
      4'h3: test_condition = f[`FLAG_SF_BIT];
      4'h4: test_condition = ~f[`FLAG_SF_BIT];
      4'h5: test_condition = f[`FLAG_TF1_BIT];
      4'h6: test_condition = f[`FLAG_TF2_BIT];
      default: test_condition = 1'b0;
    endcase
  end
endfunction
function [5:0] step_ptr;
  input [5:0] p;
  input [1:0] n;
  begin
    case (n)
      `NEXT_INC: step_ptr = p + 6'h01;
      `NEXT_DEC: step_ptr = p - 6'h01;
      default:   step_ptr = p;
    endcase
  end
endfunction
////////////////////////////////////////////////////////////////////////////////
// operand selection after pointer pre-step
wire [5:0]  ptr_now  = accum_pointer_reg[sel];
wire [5:0]  ptr_new  = step_ptr(ptr_now, nxt);
wire [1:0]  aidx     = ptr_new[1:0];
wire [15:0] acc_src  = alt ? accum_offset_reg[aidx] : accum_reg[aidx];
wire [1:0]  fl_tf    = tf_sel ? 2'h1 : 2'h0;
////////////////////////////////////////////////////////////////////////////////
// ahb-lite slave
reg [31:0] rdata_d;
always @*
begin
  rdata_d = 32'h00000000;
  case (ph_addr_q)
    `ADDR_CTRL:     rdata_d = ctrl_q;
    `ADDR_OPERAND:  rdata_d = {16'h0000, operand_q};
    `ADDR_MEMDATA:  rdata_d = {16'h0000, memdata_q};
    `ADDR_ROMDATA:  rdata_d = {16'h0000, romdata_q};
    `ADDR_RESULT:   rdata_d = {16'h0000, result_q};
    `ADDR_STATUS:   rdata_d = {31'h0, result_wr_q};
    `ADDR_SHIFT:    rdata_d = {28'h0000000, shift_amount_reg};
    `ADDR_MULT:     rdata_d = {16'h0000, multiplier_operand_reg};
    `ADDR_PHIGH:    rdata_d = {16'h0000, product_high_reg};
    `ADDR_REPLEN:   rdata_d = {24'h000000, repeat_length_reg};
    `ADDR_FLAGS:    rdata_d = {16'h0000, flags_q};
    `ADDR_STACKTOP: rdata_d = {16'h0000, stack_top_reg};
    `ADDR_DPAGE:    rdata_d = {16'h0000, data_page_pointer};
    default:
    begin
      if (ph_addr_q[7:4] == 4'h2)
        rdata_d = {16'h0000, accum_reg[ph_addr_q[3:2]]};
      else if (ph_addr_q[7:4] == 4'h3)
        rdata_d = {16'h0000, accum_offset_reg[ph_addr_q[3:2]]};
      else if (ph_addr_q[7:4] == 4'h4)
        rdata_d = {26'h0, accum_pointer_reg[ph_addr_q[3:2]]};
    end
  endcase
end
always @(posedge REF_CLK or negedge rst_n)
begin
  if (!rst_n)
  begin
    ph_q      <= 1'b0;
    ph_wr_q   <= 1'b0;
    ph_addr_q <= 8'h00;
    HRDATA    <= 32'h00000000;
    HREADYOUT <= 1'b1;
    HRESP     <= 1'b0;
  end
  else
  begin
    ph_q      <= HSEL & HREADY & HTRANS[1];
    ph_wr_q   <= HWRITE;
    if (HSEL & HREADY & HTRANS[1])
      ph_addr_q <= {HADDR[7:2], 2'b00};
    HRDATA    <= rdata_d;
    HREADYOUT <= ~(HSEL & HREADY & HTRANS[1] & ~HWRITE);
    HRESP     <= 1'b0;
  end
end
wire bus_wr = ph_q & ph_wr_q;
////////////////////////////////////////////////////////////////////////////////
// executor
always @(posedge REF_CLK or negedge rst_n)
begin
  if (!rst_n)
  begin
    ctrl_q <= 32'h00000000;
    operand_q <= 16'h0000;
    memdata_q <= 16'h0000;
    romdata_q <= 16'h0000;
    result_q <= 16'h0000;
    result_wr_q <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      accum_reg[i] <= 16'h0000;
      accum_offset_reg[i] <= 16'h0000;
      accum_pointer_reg[i] <= 6'h00;
    end
    shift_amount_reg <= 4'h0;
    multiplier_operand_reg <= 16'h0000;
    product_high_reg <= 16'h0000;
    repeat_length_reg <= 8'h00;
    flags_q <= 16'h0000;
    stack_top_reg <= 16'h0000;
    data_page_pointer <= 16'h0000;
  end
  else if (go)
  begin
    ctrl_q[`CTRL_GO_BIT] <= 1'b0;
    result_wr_q <= 1'b0;
    case (form)
      `FORM_LD_MEM,
      `FORM_LD_IMM,
      `FORM_MR_IMM,
      `FORM_ACC_X,
      `FORM_LD_PH,
      `FORM_ST_ACC,
      `FORM_SV_ACC,
      `FORM_PH_ACC,
      `FORM_MR_ACC,
      `FORM_TBL:
        accum_pointer_reg[sel] <= ptr_new;
      default:
        accum_pointer_reg[sel] <= ptr_now;
    endcase
    case (form)
      `FORM_LD_MEM, `FORM_LD_IMM, `FORM_LD_PH, `FORM_TBL, `FORM_ACC_X:
      begin
        if (alt)
          accum_offset_reg[aidx] <= (form == `FORM_LD_MEM) ? memdata_q :
            (form == `FORM_LD_IMM) ? operand_q : (form == `FORM_LD_PH) ? product_high_reg :
            (form == `FORM_TBL) ? romdata_q : accum_reg[aidx];
        else
          accum_reg[aidx] <= (form == `FORM_LD_MEM) ? memdata_q :
            (form == `FORM_LD_IMM) ? operand_q : (form == `FORM_LD_PH) ? product_high_reg :
            (form == `FORM_TBL) ? romdata_q : accum_offset_reg[aidx];
        if (form != `FORM_ACC_X)
          flags_q <= set_cond(flags_q, (form == `FORM_LD_MEM) ? memdata_q :
            (form == `FORM_LD_IMM) ? operand_q : (form == `FORM_LD_PH) ? product_high_reg :
            romdata_q);
      end
      `FORM_ST_ACC:  begin result_q <= acc_src; result_wr_q <= 1'b1; end
      `FORM_MR_IMM:  multiplier_operand_reg <= operand_q;
      `FORM_SV_ACC:  shift_amount_reg <= acc_src[3:0];
      `FORM_PH_ACC:  product_high_reg <= acc_src;
      `FORM_MR_ACC, `FORM_MR_MEM:
      begin
        multiplier_operand_reg <= (form == `FORM_MR_ACC) ? acc_src : memdata_q;
        flags_q[`FLAG_UM_BIT] <= 1'b0;
      end
      `FORM_PH_MEM:  product_high_reg <= memdata_q;
      `FORM_ST_ROM:  begin result_q <= romdata_q; result_wr_q <= 1'b1; end
      `FORM_AP_MEM:  accum_pointer_reg[sel] <= memdata_q[5:0];
      `FORM_FL_MEM:  flags_q <= memdata_q;
      `FORM_SV_MEM:  shift_amount_reg <= memdata_q[3:0];
      `FORM_TOS_MEM: stack_top_reg <= memdata_q;
      `FORM_ST_PH:   begin result_q <= product_high_reg; result_wr_q <= 1'b1; end
      `FORM_ST_MR:   begin result_q <= multiplier_operand_reg; result_wr_q <= 1'b1; end
      `FORM_ST_FL:   begin result_q <= flags_q; result_wr_q <= 1'b1; end
      `FORM_ST_STR:  begin result_q <= {8'h00, repeat_length_reg}; result_wr_q <= 1'b1; end
      `FORM_ST_DP:   begin result_q <= data_page_pointer; result_wr_q <= 1'b1; end
      `FORM_ST_SV:   begin result_q <= {12'h000, shift_amount_reg}; result_wr_q <= 1'b1; end
      `FORM_ST_AP:   begin result_q <= {10'h000, ptr_now}; result_wr_q <= 1'b1; end
      `FORM_STR_MEM: repeat_length_reg <= memdata_q[7:0];
      `FORM_ST_TOS:  begin result_q <= stack_top_reg; result_wr_q <= 1'b1; end
      `FORM_TF_CC:
      begin
        if (fl_tf == 2'h1)
          flags_q[`FLAG_TF2_BIT] <= test_condition(cc, flags_q);
        else
          flags_q[`FLAG_TF1_BIT] <= test_condition(cc, flags_q);
      end
      `FORM_SV_IMM:  shift_amount_reg <= operand_q[3:0];
      `FORM_STR_IMM: repeat_length_reg <= operand_q[7:0];
      `FORM_AP_IMM:  accum_pointer_reg[sel] <= {1'b0, operand_q[4:0]};
      default:       result_wr_q <= 1'b0;
    endcase
  end
  else if (bus_wr)
  begin
    case (ph_addr_q)
      `ADDR_CTRL:     ctrl_q <= HWDATA;
      `ADDR_OPERAND:  operand_q <= HWDATA[15:0];
      `ADDR_MEMDATA:  memdata_q <= HWDATA[15:0];
      `ADDR_ROMDATA:  romdata_q <= HWDATA[15:0];
      `ADDR_STATUS:   result_wr_q <= 1'b0;
      `ADDR_PHIGH:    product_high_reg <= HWDATA[15:0];
      `ADDR_FLAGS:    flags_q <= HWDATA[15:0];
      `ADDR_DPAGE:    data_page_pointer <= HWDATA[15:0];
      default:
      begin
        if (ph_addr_q[7:4] == 4'h2)
          accum_reg[ph_addr_q[3:2]] <= HWDATA[15:0];
        else if (ph_addr_q[7:4] == 4'h3)
          accum_offset_reg[ph_addr_q[3:2]] <= HWDATA[15:0];
        else if (ph_addr_q[7:4] == 4'h4)
          accum_pointer_reg[ph_addr_q[3:2]] <= HWDATA[5:0];
      end
    endcase
  end
end
endmodule

// ### mov_exec_consts.vh
// constants for the word move executor
`ifndef MOV_EXEC_CONSTS_VH
`define MOV_EXEC_CONSTS_VH
`define ADDR_CTRL        32'h00000000
`define ADDR_OPERAND     32'h00000004
`define ADDR_MEMDATA     32'h00000008
`define ADDR_ROMDATA     32'h0000000C
`define ADDR_RESULT      32'h00000010
`define ADDR_STATUS      32'h00000014
`define ADDR_ACCUM0      32'h00000020
`define ADDR_ACCOFF0     32'h00000030
`define ADDR_APTR0       32'h00000040
`define ADDR_SHIFT       32'h00000050
`define ADDR_MULT        32'h00000054
`define ADDR_PHIGH       32'h00000058
`define ADDR_REPLEN      32'h0000005C
`define ADDR_FLAGS       32'h00000060
`define ADDR_STACKTOP    32'h00000064
`define ADDR_DPAGE       32'h00000068
`define CTRL_FORM_LSB    0
`define CTRL_SEL_LSB     8
`define CTRL_ALT_BIT     10
`define CTRL_NEXT_LSB    12
`define CTRL_TF_BIT      14
`define CTRL_CC_LSB      16
`define CTRL_GO_BIT      31
`define FLAG_UM_BIT      1
`define FLAG_ZF_BIT      2
`define FLAG_SF_BIT      3
`define FLAG_TF1_BIT     4
`define FLAG_TF2_BIT     5
`define NEXT_NONE        2'h0
`define NEXT_INC         2'h1
`define NEXT_DEC         2'h2
`define FORM_LD_MEM      5'h00
`define FORM_ST_ACC      5'h01
`define FORM_LD_IMM      5'h02
`define FORM_MR_IMM      5'h03
`define FORM_ACC_X       5'h04
`define FORM_LD_PH       5'h05
`define FORM_SV_ACC      5'h06
`define FORM_PH_ACC      5'h07
`define FORM_MR_ACC      5'h08
`define FORM_TBL         5'h09
`define FORM_PH_MEM      5'h0A
`define FORM_MR_MEM      5'h0B
`define FORM_ST_ROM      5'h0C
`define FORM_AP_MEM      5'h0D
`define FORM_FL_MEM      5'h0E
`define FORM_SV_MEM      5'h0F
`define FORM_TOS_MEM     5'h10
`define FORM_ST_PH       5'h11
`define FORM_ST_MR       5'h12
`define FORM_ST_FL       5'h13
`define FORM_ST_STR      5'h14
`define FORM_ST_DP       5'h15
`define FORM_ST_SV       5'h16
`define FORM_ST_AP       5'h17
`define FORM_STR_MEM     5'h18
`define FORM_ST_TOS      5'h19
`define FORM_TF_CC       5'h1A
`define FORM_SV_IMM      5'h1B
`define FORM_STR_IMM     5'h1C
`define FORM_AP_IMM      5'h1D
`endif

// ### move_instruction_executor_asserts.sv
// bus-side checker for the word move executor
`include "mov_exec_consts.vh"
module move_exec_checker
(
  input wire        REF_CLK,
  input wire        RST_N,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [2:0]  HSIZE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire [31:0] HRDATA,
  input wire        HREADYOUT,
  input wire        HRESP
);
  wire        taken;
  reg         pend_q;
  reg  [31:0] addr_q;
  assign taken = HSEL & HREADY & HTRANS[1];
  ////////////////////////////////////////////////////////////////////////////////
  // read data phase tracking
  always @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pend_q <= 1'b0;
      addr_q <= 32'h00000000;
    end
    else if (taken)
    begin
      pend_q <= ~HWRITE;
      addr_q <= HADDR;
    end
    else if (HREADYOUT)
      pend_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_rd_done;
    pend_q && HREADYOUT;
  endsequence
  property p_resp;
    HRESP == 1'b0;
  endproperty
  property p_rd_wait;
    taken && !HWRITE |=> s_rd_wait;
  endproperty
  property p_wr_fast;
    taken && HWRITE |=> HREADYOUT;
  endproperty
  property p_low_once;
    $fell(HREADYOUT) |=> HREADYOUT;
  endproperty
  property p_upper_zero;
    s_rd_done and (addr_q != `ADDR_CTRL) |-> HRDATA[31:16] == 16'h0000;
  endproperty
  property p_unmapped;
    s_rd_done and (addr_q > `ADDR_DPAGE) |-> HRDATA == 32'h00000000;
  endproperty
  property p_sv_width;
    s_rd_done and (addr_q == `ADDR_SHIFT) |-> HRDATA[31:4] == 28'h0000000;
  endproperty
  property p_ap_width;
    s_rd_done and (addr_q[31:4] == 28'h0000004) |-> HRDATA[31:6] == 26'h0000000;
  endproperty
  property p_str_width;
    s_rd_done and (addr_q == `ADDR_REPLEN) |-> HRDATA[31:8] == 24'h000000;
  endproperty
  a_resp:       assert property (p_resp) else $error("response not okay");
  a_rd_wait:    assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_fast:    assert property (p_wr_fast) else $error("write data phase stalled");
  a_low_once:   assert property (p_low_once) else $error("ready low too long");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_sv_width:   assert property (p_sv_width) else $error("shift amount too wide");
  a_ap_width:   assert property (p_ap_width) else $error("pointer too wide");
  a_str_width:  assert property (p_str_width) else $error("repeat length too wide");
endmodule
bind move_instruction_executor move_exec_checker move_exec_checker_i (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP));

// ### testbench.sv
// self-checking bench for the word move executor
`include "mov_exec_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        REF_CLK, RST_N, HSEL, HWRITE;
  logic [31:0] HADDR, HWDATA, rd;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  wire  [31:0] HRDATA;
  wire         HREADYOUT, HRESP;
  int          fails, check_count, cyc, i;
  logic [6:0]  tf_exp;
  move_instruction_executor move_instruction_executor_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP));
  initial
  begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge REF_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      give_verdict;
    end
  end
  // single ahb-lite transfer, entered just after a rising edge
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    HSEL <= 1'h1;
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'h2;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'h1) @(posedge REF_CLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'h1) @(posedge REF_CLK);
    rd = HRDATA;
  endtask
  task chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'h0, a, 32'h00000000);
    check_count = check_count + 1;
    if ((rd & m) !== e)
    begin
      $display("[ERR] reg %h expected %h seen %h", a, e, rd & m);
      fails = fails + 1;
    end
  endtask
  function logic [31:0] cw(input logic [4:0] f, input logic [1:0] s, input logic [1:0] n,
                           input logic t, input logic [3:0] c);
    cw = {12'h000, c, 1'h0, t, n, 2'h0, s, 3'h0, f};
  endfunction
  // operand and fetched word set to v, then instruction launched and polled
  task ex(input logic [31:0] c, input logic [15:0] v);
    ahb(1'h1, `ADDR_OPERAND, {16'h0000, v});
    ahb(1'h1, `ADDR_MEMDATA, {16'h0000, v});
    ahb(1'h1, `ADDR_CTRL, c | 32'h80000000);
    rd = ALL;
    for (int k = 0; k < 8 && rd[31] !== 1'h0; k++) ahb(1'h0, `ADDR_CTRL, 32'h00000000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {HSEL, HADDR, HTRANS, HWRITE, HWDATA, RST_N} = '0;
    HSIZE = 3'h2;
    fails = 0;
    check_count = 0;
    cyc = 0;
    repeat (20) @(posedge REF_CLK);
    RST_N <= 1'h1;
    repeat (4) @(posedge REF_CLK);
    ahb(1'h1, `ADDR_APTR0, 32'h00000001);
    ahb(1'h1, `ADDR_ACCUM0 + 32'h8, 32'h000000AB);
    ahb(1'h1, `ADDR_ACCUM0 + 32'h4, 32'h00000035);
    ex(cw(`FORM_SV_ACC, 2'h0, `NEXT_INC, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_APTR0, ALL, 32'h00000002);
    chk(`ADDR_SHIFT, ALL, 32'h0000000B);
    ex(cw(`FORM_SV_ACC, 2'h0, `NEXT_DEC, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_APTR0, ALL, 32'h00000001);
    chk(`ADDR_SHIFT, ALL, 32'h00000005);
    ex(cw(`FORM_LD_IMM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_ACCUM0 + 32'h4, ALL, 32'h00000000);
    chk(`ADDR_FLAGS, 32'h0000000C, 32'h00000004);
    ex(cw(`FORM_LD_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h8000);
    chk(`ADDR_ACCUM0 + 32'h4, ALL, 32'h00008000);
    chk(`ADDR_FLAGS, 32'h0000000C, 32'h00000008);
    tf_exp = 7'h0D;
    for (i = 0; i < 7; i++)
    begin
      ahb(1'h1, `ADDR_FLAGS, 32'h00000008);
      ex(cw(`FORM_TF_CC, 2'h0, `NEXT_NONE, 1'h1, i[3:0]), 16'h0000);
      chk(`ADDR_FLAGS, ALL, 32'h00000008 | ({31'h0, tf_exp[i]} << 5));
    end
    ahb(1'h1, `ADDR_FLAGS, 32'h00000008);
    ex(cw(`FORM_TF_CC, 2'h0, `NEXT_NONE, 1'h0, 4'h3), 16'h0000);
    chk(`ADDR_FLAGS, ALL, 32'h00000018);
    ahb(1'h1, `ADDR_FLAGS, 32'h00000002);
    ex(cw(`FORM_MR_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h1234);
    chk(`ADDR_MULT, ALL, 32'h00001234);
    chk(`ADDR_FLAGS, 32'h00000002, 32'h00000000);
    ahb(1'h1, `ADDR_FLAGS, 32'h00000002);
    ex(cw(`FORM_MR_ACC, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_MULT, ALL, 32'h00008000);
    chk(`ADDR_FLAGS, 32'h00000002, 32'h00000000);
    ex(cw(`FORM_PH_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h7777);
    chk(`ADDR_PHIGH, ALL, 32'h00007777);
    chk(`ADDR_MULT, ALL, 32'h00008000);
    ahb(1'h1, `ADDR_ROMDATA, 32'h00004321);
    ex(cw(`FORM_TBL, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_ACCUM0 + 32'h4, ALL, 32'h00004321);
    ex(cw(`FORM_ST_ROM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_RESULT, ALL, 32'h00004321);
    ex(cw(`FORM_FL_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h1235);
    chk(`ADDR_FLAGS, ALL, 32'h00001235);
    ex(cw(`FORM_SV_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'hABCD);
    chk(`ADDR_SHIFT, ALL, 32'h0000000D);
    ex(cw(`FORM_ST_SV, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_RESULT, ALL, 32'h0000000D);
    ex(cw(`FORM_SV_IMM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'hFFF7);
    chk(`ADDR_SHIFT, ALL, 32'h00000007);
    ex(cw(`FORM_AP_MEM, 2'h1, `NEXT_NONE, 1'h0, 4'h0), 16'hFFFF);
    chk(`ADDR_APTR0 + 32'h4, ALL, 32'h0000003F);
    ex(cw(`FORM_AP_IMM, 2'h2, `NEXT_NONE, 1'h0, 4'h0), 16'hFFFF);
    chk(`ADDR_APTR0 + 32'h8, ALL, 32'h0000001F);
    ex(cw(`FORM_STR_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'hABCD);
    chk(`ADDR_REPLEN, ALL, 32'h000000CD);
    ex(cw(`FORM_STR_IMM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h1234);
    chk(`ADDR_REPLEN, ALL, 32'h00000034);
    ex(cw(`FORM_ST_STR, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_RESULT, ALL, 32'h00000034);
    ex(cw(`FORM_TOS_MEM, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h5A5A);
    chk(`ADDR_STACKTOP, ALL, 32'h00005A5A);
    ex(cw(`FORM_ST_TOS, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_RESULT, ALL, 32'h00005A5A);
    ahb(1'h1, `ADDR_DPAGE, 32'h00000042);
    ex(cw(`FORM_ST_DP, 2'h0, `NEXT_NONE, 1'h0, 4'h0), 16'h0000);
    chk(`ADDR_RESULT, ALL, 32'h00000042);
    chk(32'h00000080, ALL, 32'h00000000);
    give_verdict;
  end
endmodule
